// file: design/btc_clock_control.sv
/*
 * Basic timer control, watchdog enable and CPU clock divider control.
 * Assumes the core presents synchronous register requests on clk_sys_in,
 * which is the oscillator clock fxx itself.
 */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RQ1: Watchdog is disabled only while timer control bits 7..4 equal 1010.
// RQ2: Prescale select 01 gives fxx/1024, 10 gives fxx/128, 11 invalid.
// RQ3: Writing one to bit 1 clears the basic timer counter; zero does nothing.
// RQ4: Writing one to bit 0 clears the shared frequency dividers; zero does nothing.
// RQ5: Both clear bits return to zero by themselves and read back as zero.
// RQ6: Clock control bit 7 high blocks the wake-up interrupt in power-down.
// RQ7: Clock control bits 4..3 pick fxx/16, fxx/8, fxx/2 or fxx.
// RQ8: After reset the CPU clock runs at fxx/16 until software changes it.
// RQ9: Both registers answer only register addressing in the upper register set.
// RQ10: Prescale select 00 is treated as fxx/4096.
// RQ11: Unused clock control bits ignore writes and affect nothing.
module btc_clock_control
	import btc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	// Register port
	input wire btc_req_s req_in,
	output logic [7:0] rdata_out,
	output logic rvalid_out,
	// Power-down wake-up
	input wire logic wake_irq_in,
	output logic wake_ok_out,
	// Controls to the timers and core
	output logic wdt_en_out,
	output logic bt_tick_out,
	output logic bt_cnt_clr_out,
	output logic div_clr_out,
	output logic cpu_tick_out
);
	// Registered state and its next value.
	btc_state_s state_reg;
	btc_state_s state_next;

	// Request decode.
	logic hit;
	logic wr_timer;
	logic wr_clock;
	logic rd_timer;
	logic rd_clock;

	// Field views of the stored registers.
	logic [3:0] wdt_code;
	logic [1:0] bt_sel;
	logic [1:0] cpu_sel;
	logic wake_block;

	// Per-bit keep masks: a stored bit takes write data only where its mask is set.
	logic [7:0] timer_keep;
	logic [7:0] clock_keep;

	// Divider taps.
	logic [11:0] bt_term;
	logic [11:0] cpu_term;
	logic bt_valid;
	logic bt_match;
	logic cpu_match;
	logic [11:0] div_inc;

	genvar bit_idx;

	generate
		for (bit_idx = 0; bit_idx < 8; bit_idx++) begin : g_keep
			// The clear bits are strobes, never stored, so software always reads them as zero.
			assign timer_keep[bit_idx] = (bit_idx != BTC_CNT_CLR_BIT) && (bit_idx != BTC_DIV_CLR_BIT); // see RQ5
			assign clock_keep[bit_idx] = BTC_CLOCK_CTRL_MASK[bit_idx]; // see RQ11
		end
	endgenerate

	// Only register addressing in the upper register set reaches the two registers.
	assign hit = req_in.valid && req_in.reg_mode && req_in.set_upper; // see RQ9
	assign wr_timer = hit && req_in.write && (req_in.addr == BTC_ADDR_TIMER_CTRL);
	assign wr_clock = hit && req_in.write && (req_in.addr == BTC_ADDR_CLOCK_CTRL);
	assign rd_timer = hit && !req_in.write && (req_in.addr == BTC_ADDR_TIMER_CTRL);
	assign rd_clock = hit && !req_in.write && (req_in.addr == BTC_ADDR_CLOCK_CTRL);

	assign wdt_code = state_reg.timer_ctrl[BTC_WDT_HI:BTC_WDT_LO];
	assign bt_sel = state_reg.timer_ctrl[BTC_SEL_HI:BTC_SEL_LO];
	assign cpu_sel = state_reg.clock_ctrl[BTC_CPU_HI:BTC_CPU_LO];
	assign wake_block = state_reg.clock_ctrl[BTC_WAKE_BLOCK_BIT];

	// Basic timer prescale tap.
	always_comb begin
		bt_term = BTC_TERM_4096;
		bt_valid = 1'b1;
		case (bt_sel)
			2'h0: begin
				bt_term = BTC_TERM_4096; // see RQ10
			end
			2'h1: begin
				bt_term = BTC_TERM_1024; // see RQ2
			end
			2'h2: begin
				bt_term = BTC_TERM_128; // see RQ2
			end
			default: begin
				// Code 11 is invalid; it yields no timer tick at all rather than a guessed rate.
				bt_term = BTC_DIV_ALL_ONES;
				bt_valid = 1'b0; // see RQ2
			end
		endcase
	end

	// CPU clock tap.
	always_comb begin
		cpu_term = BTC_TERM_16;
		case (cpu_sel)
			2'h0: begin
				cpu_term = BTC_TERM_16; // see RQ8
			end
			2'h1: begin
				cpu_term = BTC_TERM_8; // see RQ7
			end
			2'h2: begin
				cpu_term = BTC_TERM_2; // see RQ7
			end
			default: begin
				cpu_term = BTC_TERM_1; // see RQ7
			end
		endcase
	end

	// One free-running divider feeds both taps, so clearing it realigns every rate.
	assign div_inc = state_reg.div + 12'h0001;
	assign bt_match = bt_valid && ((state_reg.div & bt_term) == bt_term);
	assign cpu_match = (state_reg.div & cpu_term) == cpu_term;

	always_comb begin
		state_next = state_reg;

		// Strobes and the read answer last one cycle unless renewed.
		state_next.bt_cnt_clr = 1'b0;
		state_next.div_clr = 1'b0;
		state_next.rvalid = 1'b0;

		// Basic timer control write; the clear bits act once and are not kept.
		if (wr_timer) begin
			state_next.timer_ctrl = req_in.wdata & timer_keep; // see RQ5
			state_next.bt_cnt_clr = req_in.wdata[BTC_CNT_CLR_BIT]; // see RQ3
			state_next.div_clr = req_in.wdata[BTC_DIV_CLR_BIT]; // see RQ4
		end

		// Clock control write.
		if (wr_clock) begin
			state_next.clock_ctrl = req_in.wdata & clock_keep; // see RQ11
		end

		// Read answer; rdata holds until the next read hit.
		if (rd_timer) begin
			state_next.rvalid = 1'b1;
			state_next.rdata = state_reg.timer_ctrl;
		end
		if (rd_clock) begin
			state_next.rvalid = 1'b1;
			state_next.rdata = state_reg.clock_ctrl;
		end

		// Levels that follow the stored registers one cycle later.
		state_next.wdt_en = wdt_code != BTC_WDT_DISABLE_CODE; // see RQ1
		state_next.wake_ok = wake_irq_in && !wake_block; // see RQ6

		// A divider clear suppresses both ticks for the cycle in which it acts.
		if (state_reg.div_clr) begin
			state_next.div = '0; // see RQ4
			state_next.bt_tick = 1'b0;
			state_next.cpu_tick = 1'b0;
		end else begin
			state_next.div = div_inc;
			state_next.bt_tick = bt_match; // see RQ2
			state_next.cpu_tick = cpu_match; // see RQ7
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= '0;
			state_reg.timer_ctrl <= BTC_TIMER_CTRL_RESET;
			state_reg.clock_ctrl <= BTC_CLOCK_CTRL_RESET; // see RQ8
			// The watchdog stays armed through reset, since both registers reset to zero.
			state_reg.wdt_en <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata_out = state_reg.rdata;
	assign rvalid_out = state_reg.rvalid;
	assign wake_ok_out = state_reg.wake_ok;
	assign wdt_en_out = state_reg.wdt_en;
	assign bt_tick_out = state_reg.bt_tick;
	assign bt_cnt_clr_out = state_reg.bt_cnt_clr;
	assign div_clr_out = state_reg.div_clr;
	assign cpu_tick_out = state_reg.cpu_tick;
endmodule
`default_nettype wire

// file: shared/btc_pkg.sv
/*
 * Package for the basic timer and clock control block: register addresses,
 * field positions, reset values and divider ratios.
 * Assumes an 8-bit register port on the core's special-register bus.
 */
`default_nettype none
package btc_pkg;
	localparam logic [7:0] BTC_ADDR_TIMER_CTRL = 8'h00_D3;
	localparam logic [7:0] BTC_ADDR_CLOCK_CTRL = 8'h00_D4;
	localparam logic [7:0] BTC_TIMER_CTRL_RESET = 8'h00_00;
	localparam logic [7:0] BTC_CLOCK_CTRL_RESET = 8'h00_00;
	localparam logic [7:0] BTC_CLOCK_CTRL_MASK = 8'h00_98;
	localparam logic [3:0] BTC_WDT_DISABLE_CODE = 4'h000A;
	localparam int BTC_WDT_HI = 7;
	localparam int BTC_WDT_LO = 4;
	localparam int BTC_SEL_HI = 3;
	localparam int BTC_SEL_LO = 2;
	localparam int BTC_CNT_CLR_BIT = 1;
	localparam int BTC_DIV_CLR_BIT = 0;
	localparam int BTC_WAKE_BLOCK_BIT = 7;
	localparam int BTC_CPU_HI = 4;
	localparam int BTC_CPU_LO = 3;
	localparam int BTC_DIV_W = 12;
	localparam logic [11:0] BTC_DIV_ALL_ONES = 12'h0FFF;
	// Basic timer prescale terminal counts (ratio minus one).
	localparam logic [11:0] BTC_TERM_4096 = 12'h0FFF;
	localparam logic [11:0] BTC_TERM_1024 = 12'h03FF;
	localparam logic [11:0] BTC_TERM_128 = 12'h007F;
	// CPU clock terminal counts (ratio minus one).
	localparam logic [11:0] BTC_TERM_16 = 12'h000F;
	localparam logic [11:0] BTC_TERM_8 = 12'h0007;
	localparam logic [11:0] BTC_TERM_2 = 12'h0001;
	localparam logic [11:0] BTC_TERM_1 = 12'h0000;

	typedef struct packed {
		logic valid;
		logic write;
		logic reg_mode;
		logic set_upper;
		logic [7:0] addr;
		logic [7:0] wdata;
	} btc_req_s;

	typedef struct packed {
		logic [7:0] timer_ctrl;
		logic [7:0] clock_ctrl;
		logic [11:0] div;
		logic [7:0] rdata;
		logic rvalid;
		logic bt_tick;
		logic cpu_tick;
		logic bt_cnt_clr;
		logic div_clr;
		logic wdt_en;
		logic wake_ok;
	} btc_state_s;
endpackage
`default_nettype wire

// file: tb/btc_clock_control_properties.sv
/* Checker of btc_clock_control ports. Assumes one clock and async reset. */
`timescale 1ns/10ps
`default_nettype none
module btc_clock_control_properties
	import btc_pkg::*;
(
	input wire logic clk_sys_in, rstn_in, wake_irq_in, rvalid_out, wake_ok_out,
	input wire logic wdt_en_out, bt_tick_out, bt_cnt_clr_out, div_clr_out, cpu_tick_out,
	input wire btc_req_s req_in
);
	wire logic hit = req_in.valid && req_in.reg_mode && req_in.set_upper;
	wire logic wr3 = hit && req_in.write && req_in.addr == BTC_ADDR_TIMER_CTRL;
	wire logic rd = hit && !req_in.write && req_in.addr inside {8'h00_D3, 8'h00_D4};
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	wdt_code_a: assert property (wr3 |-> ##2 wdt_en_out == ($past(req_in.wdata[7:4], 2) != 4'h000A))
		else $error("wdt");
	cnt_clr_a: assert property (wr3 |=> bt_cnt_clr_out == $past(req_in.wdata[1])) else $error("cnt");
	div_clr_a: assert property (wr3 |=> div_clr_out == $past(req_in.wdata[0])) else $error("div");
	clr_cause_a: assert property (bt_cnt_clr_out || div_clr_out |-> $past(wr3)) else $error("clr");
	read_hit_a: assert property (rvalid_out == $past(rd)) else $error("rvalid");
	wake_gate_a: assert property (wake_ok_out |-> $past(wake_irq_in)) else $error("wake");
	tick_gap_a: assert property (bt_tick_out |=> !bt_tick_out) else $error("tick");
	reset_out_a: assert property (disable iff (1'b0) !rstn_in |-> wdt_en_out && !cpu_tick_out)
		else $error("reset");
	cover property (wr3 && req_in.wdata[1]);
	cover property (rvalid_out);
	cover property (bt_tick_out);
endmodule
bind btc_clock_control btc_clock_control_properties btc_clock_control_properties_inst(.*);
`default_nettype wire

// file: tb/btc_clock_control_tb_top.sv
/* Testbench of btc_clock_control. Assumes btc_pkg and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module btc_clock_control_tb_top
	import btc_pkg::*;
;
	logic clk_sys_in = 0, rstn_in = 1, wake_irq_in = 0, rvalid_out, wake_ok_out, wdt_en_out;
	logic bt_tick_out, bt_cnt_clr_out, div_clr_out, cpu_tick_out;
	logic [7:0] rdata_out, d, exp_q[$];
	btc_req_s req_in = '0;
	int bad_count = 0, n_compared = 0, nc, nb, sh[4] = '{4, 3, 1, 0}, bt[4] = '{1, 4, 32, 0};
	always #5 clk_sys_in = ~clk_sys_in;
	btc_clock_control btc_clock_control_inst(.*);
	task chk(input string s, input logic [31:0] seen, want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", s, want, seen);
		end
	endtask
	task summarize;
		$display("mismatches %0d compares %0d", bad_count, n_compared);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task rw(input logic w, m, input logic [7:0] a, v);
		@(posedge clk_sys_in);
		req_in <= '{1'b1, w, m, 1'b1, a, v};
		@(posedge clk_sys_in);
		req_in.valid <= 1'b0;
	endtask
	task rd(input logic [7:0] a, e);
		exp_q.push_back(e);
		rw(0, 1, a, 0);
	endtask
	task cnt(input int c);
		nc = 0;
		nb = 0;
		repeat (c) begin
			@(posedge clk_sys_in);
			nc += cpu_tick_out;
			nb += bt_tick_out;
		end
	endtask
	// An unexpected read answer compares against unknown and so always fails.
	always @(posedge clk_sys_in)
		if (rvalid_out === 1'b1)
			chk("rdata", rdata_out, exp_q.size() ? exp_q.pop_front() : 8'hxx);
	initial begin
		repeat (40000) @(posedge clk_sys_in);
		bad_count++;
		summarize;
	end
	initial begin
		void'($urandom(84));
		rstn_in <= 1'b0;
		repeat (6) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		rd(BTC_ADDR_TIMER_CTRL, 8'h00_00);
		cnt(64);
		chk("cpu reset", nc, 4);
		for (int i = 0; i < 4; i++) begin
			rw(1, 1, BTC_ADDR_CLOCK_CTRL, 8'(i << 3));
			rw(1, 1, BTC_ADDR_TIMER_CTRL, 8'(i << 2));
			cnt(4096);
			chk("cpu", nc, 4096 >> sh[i]);
			chk("bt", nb, bt[i]);
		end
		for (int i = 0; i < 6; i++) begin
			d = i ? 8'($urandom) : 8'h00_A3;
			rw(1, 1, BTC_ADDR_TIMER_CTRL, d);
			rd(BTC_ADDR_TIMER_CTRL, d & 8'h00_FC);
			chk("wdt", wdt_en_out, d[7:4] != 4'h000A);
			rw(1, 1, BTC_ADDR_CLOCK_CTRL, d);
			rd(BTC_ADDR_CLOCK_CTRL, d & 8'h00_98);
		end
		rw(1, 0, BTC_ADDR_TIMER_CTRL, 8'h00_00);
		rw(0, 1, 8'h00_D5, 8'h00_00);
		rd(BTC_ADDR_TIMER_CTRL, d & 8'h00_FC);
		rw(1, 1, BTC_ADDR_TIMER_CTRL, 8'h00_03);
		cnt(1);
		chk("cnt clr", bt_cnt_clr_out, 1);
		chk("div clr", div_clr_out, 1);
		cnt(1);
		chk("clr end", {bt_cnt_clr_out, div_clr_out}, 0);
		wake_irq_in <= 1'b1;
		rw(1, 1, BTC_ADDR_CLOCK_CTRL, 8'h00_80);
		cnt(3);
		chk("wake off", wake_ok_out, 0);
		rw(1, 1, BTC_ADDR_CLOCK_CTRL, 8'h00_00);
		cnt(3);
		chk("wake on", wake_ok_out, 1);
		summarize;
	end
endmodule
`default_nettype wire
